// >>> hw/clock_tick_divider.v
`timescale 1ns/1ns

// ****************************************
// Tick every divide cycles, stopped at zero
// ****************************************
module clock_tick_divider #(
    parameter WIDTH = 8
) (
    core_clk,
    reset_n,
    clk_en,
    divide,
    tick
);
    input wire core_clk;
    input wire reset_n;
    input wire clk_en;
    input wire [WIDTH-1:0] divide;
    output reg tick;

    reg [WIDTH-1:0] count_reg;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            count_reg <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (clk_en) begin
            if (divide == {WIDTH{1'b0}}) begin
                // Zero divide stops the clock outright
                count_reg <= {WIDTH{1'b0}};
                tick <= 1'b0;
            end else if (count_reg >= divide - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                // Compare with >= so a smaller new divide never overruns
                count_reg <= {WIDTH{1'b0}};
                tick <= 1'b1;
            end else begin
                count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
                tick <= 1'b0;
            end
        end
    end
endmodule // clock_tick_divider

// >>> hw/sys_config_consts.vh
`ifndef SYS_CONFIG_CONSTS_VH
`define SYS_CONFIG_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MEMORY_REMAP_CONTROL 12'h000
`define OFS_RESET_CAUSE_STATUS 12'h038
`define OFS_MAIN_CLOCK_SOURCE_SELECT 12'h050
`define OFS_MAIN_CLOCK_SOURCE_UPDATE 12'h054
`define OFS_SYSTEM_CLOCK_DIVIDER 12'h058
`define OFS_CONVERTER_CLOCK_SOURCE_SELECT 12'h064
`define OFS_CONVERTER_CLOCK_DIVIDER 12'h068
`define OFS_LOW_POWER_OSC_CLOCK_GATE 12'h07C
`define OFS_SYSTEM_CLOCK_GATE_CONTROL 12'h080
`define OFS_PERIPHERAL_RESET_CONTROL_A 12'h088
`define OFS_PERIPHERAL_RESET_CONTROL_B 12'h08C
`define OFS_SERIAL_PORT_A_CLOCK_SELECT 12'h090
`define OFS_SERIAL_PORT_B_CLOCK_SELECT 12'h094
`define OFS_TWO_WIRE_PORT_CLOCK_SELECT 12'h0A4
`define OFS_SYNC_SERIAL_CLOCK_SELECT 12'h0B4
`define OFS_FRACTIONAL_DIVIDER_VALUE 12'h0D0
`define OFS_FRACTIONAL_MULTIPLIER_VALUE 12'h0D4
`define OFS_FRACTIONAL_SOURCE_SELECT 12'h0D8
`define OFS_CLOCK_OUTPUT_SOURCE_SELECT 12'h0F0
`define OFS_CLOCK_OUTPUT_DIVIDER 12'h0F4
`define OFS_PIN_ROUTE_BASE 12'h178
`define OFS_PIN_ROUTE_LAST 12'h194
`define OFS_ANALOG_POWER_DOWN 12'h200
`define OFS_SLEEP_KEEP_RUNNING 12'h204
`define OFS_WAKE_ENABLE 12'h208

// ****************************************
// Reset values
// ****************************************
`define RST_MEMORY_REMAP_CONTROL 32'h0000_0002
`define RST_ZERO 32'h0000_0000
`define RST_SYSTEM_CLOCK_DIVIDER 32'h0000_0001
`define RST_LOW_POWER_OSC_CLOCK_GATE 32'h0000_0001
`define RST_SYSTEM_CLOCK_GATE_CONTROL 32'h0000_0017
`define RST_PERIPHERAL_RESET_CONTROL_A 32'h0FFF_FFFF
`define RST_PERIPHERAL_RESET_CONTROL_B 32'h0000_001F
`define RST_FUNCTION_CLOCK_SELECT 32'h0000_0007

// ****************************************
// Field positions
// ****************************************
`define FLD_UPDATE_BIT 0
`define FLD_GATE_BIT 0
`define FLD_DIV_MSB 7
`define FLD_SEL_MSB 2
`define FLD_REMAP_MSB 1
`define FLD_CAUSE_MSB 4
`define FLD_ADDR_MSB 11

`endif

// >>> hw/system_config_clock_reset_bank.v
// Overview of operation
// - Analog power-down bits switch oscillator, brown-out and comparator supplies.
// - Software picks analog blocks kept running in reduced power modes.
// - Per-source wake enables let interrupts wake chip from deep sleep.
// - Each peripheral held in reset or released by a control bit.
// - Eight pin interrupt channels, each routed from any digital pin.
// - Every register sits on a word-aligned offset.
// - Reset values are the contents seen after boot code ran.
// - Reset cause status register, read, write one to clear, zero after reset.
// - Main clock select and separate update enable, both reset zero.
// - System clock is main clock through divider resetting to one.
// - System clock divider zero stops the system clock.
// - Converter clock select and divider, both resetting to zero.
// - Low-power oscillator clock gate to watchdog timer, resets to one.
// - Clock control gates system clock to memories, peripherals, resets 17h.
// - Four serial function clock selects, each resetting to seven.
// - Fractional generator divider, multiplier, source select all reset zero.
// - Clock output pin from selectable source and divider, both reset zero.
// - Peripheral reset controls reset to FFFFFFFh and 1Fh.
`timescale 1ns/1ns
`include "sys_config_consts.vh"

module system_config_clock_reset_bank #(
    parameter PIN_CHANNELS = 8,
    parameter PIN_SEL_WIDTH = 5,
    parameter DIV_WIDTH = 8
) (
    core_clk,
    reset_n,
    clk_en,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    reset_cause_event,
    memory_remap,
    analog_power_down,
    sleep_keep_running,
    wake_enable,
    peripheral_reset_a_n,
    peripheral_reset_b_n,
    pin_interrupt_route,
    main_clock_active_select,
    system_clock_tick,
    peripheral_clock_enable,
    converter_clock_select,
    converter_clock_tick,
    watchdog_lposc_clock_enable,
    serial_port_a_source,
    serial_port_b_source,
    two_wire_port_source,
    sync_serial_source,
    fractional_divider,
    fractional_multiplier,
    fractional_source,
    clock_output_source,
    clock_output_pin
);
    input wire core_clk;
    input wire reset_n;
    input wire clk_en;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output wire hreadyout;
    output wire hresp;
    output reg [31:0] hrdata;
    input wire [`FLD_CAUSE_MSB:0] reset_cause_event;
    output wire [`FLD_REMAP_MSB:0] memory_remap;
    output reg [31:0] analog_power_down;
    output reg [31:0] sleep_keep_running;
    output reg [31:0] wake_enable;
    output wire [31:0] peripheral_reset_a_n;
    output wire [31:0] peripheral_reset_b_n;
    output wire [PIN_CHANNELS*PIN_SEL_WIDTH-1:0] pin_interrupt_route;
    output reg [`FLD_SEL_MSB:0] main_clock_active_select;
    output wire system_clock_tick;
    output reg [31:0] peripheral_clock_enable;
    output wire [`FLD_SEL_MSB:0] converter_clock_select;
    output wire converter_clock_tick;
    output wire watchdog_lposc_clock_enable;
    output wire [`FLD_SEL_MSB:0] serial_port_a_source;
    output wire [`FLD_SEL_MSB:0] serial_port_b_source;
    output wire [`FLD_SEL_MSB:0] two_wire_port_source;
    output wire [`FLD_SEL_MSB:0] sync_serial_source;
    output wire [DIV_WIDTH-1:0] fractional_divider;
    output wire [DIV_WIDTH-1:0] fractional_multiplier;
    output wire [`FLD_SEL_MSB:0] fractional_source;
    output wire [`FLD_SEL_MSB:0] clock_output_source;
    output reg clock_output_pin;

    // ****************************************
    // Register storage
    // ****************************************
    reg [31:0] memory_remap_control_reg;
    reg [31:0] reset_cause_status_reg;
    reg [31:0] main_clock_source_select_reg;
    reg [31:0] main_clock_source_update_reg;
    reg [31:0] system_clock_divider_reg;
    reg [31:0] converter_clock_source_select_reg;
    reg [31:0] converter_clock_divider_reg;
    reg [31:0] low_power_osc_clock_gate_reg;
    reg [31:0] system_clock_gate_control_reg;
    reg [31:0] peripheral_reset_control_a_reg;
    reg [31:0] peripheral_reset_control_b_reg;
    reg [31:0] serial_port_a_clock_select_reg;
    reg [31:0] serial_port_b_clock_select_reg;
    reg [31:0] two_wire_port_clock_select_reg;
    reg [31:0] sync_serial_clock_select_reg;
    reg [31:0] fractional_divider_value_reg;
    reg [31:0] fractional_multiplier_value_reg;
    reg [31:0] fractional_source_select_reg;
    reg [31:0] clock_output_source_select_reg;
    reg [31:0] clock_output_divider_reg;
    reg [PIN_SEL_WIDTH-1:0] pin_route_mem [0:PIN_CHANNELS-1];

    // ****************************************
    // Bus phase tracking
    // ****************************************
    reg write_pending_reg;
    reg read_pending_reg;
    reg [`FLD_ADDR_MSB:0] phase_addr_reg;
    wire address_taken;
    wire [`FLD_ADDR_MSB:0] offset;
    wire [31:0] read_value;
    integer i;

    // Pin route channel of an offset, or all ones if none
    function [3:0] route_channel;
        input [`FLD_ADDR_MSB:0] ofs;
        reg [`FLD_ADDR_MSB:0] delta;
        begin
            delta = ofs - `OFS_PIN_ROUTE_BASE;
            if (ofs >= `OFS_PIN_ROUTE_BASE && ofs <= `OFS_PIN_ROUTE_LAST
                    && delta[`FLD_ADDR_MSB:2] < PIN_CHANNELS)
                route_channel = delta[5:2];
            else
                route_channel = 4'hF;
        end
    endfunction

    // Read view of one word offset; reserved offsets give zero
    function [31:0] read_word;
        input [`FLD_ADDR_MSB:0] ofs;
        reg [3:0] chan;
        begin
            chan = route_channel(ofs);
            read_word = 32'h0000_0000;
            case (ofs)
                `OFS_MEMORY_REMAP_CONTROL: read_word = memory_remap_control_reg;
                `OFS_RESET_CAUSE_STATUS: read_word = reset_cause_status_reg;
                `OFS_MAIN_CLOCK_SOURCE_SELECT: read_word = main_clock_source_select_reg;
                `OFS_MAIN_CLOCK_SOURCE_UPDATE: read_word = main_clock_source_update_reg;
                `OFS_SYSTEM_CLOCK_DIVIDER: read_word = system_clock_divider_reg;
                `OFS_CONVERTER_CLOCK_SOURCE_SELECT: read_word = converter_clock_source_select_reg;
                `OFS_CONVERTER_CLOCK_DIVIDER: read_word = converter_clock_divider_reg;
                `OFS_LOW_POWER_OSC_CLOCK_GATE: read_word = low_power_osc_clock_gate_reg;
                `OFS_SYSTEM_CLOCK_GATE_CONTROL: read_word = system_clock_gate_control_reg;
                `OFS_PERIPHERAL_RESET_CONTROL_A: read_word = peripheral_reset_control_a_reg;
                `OFS_PERIPHERAL_RESET_CONTROL_B: read_word = peripheral_reset_control_b_reg;
                `OFS_SERIAL_PORT_A_CLOCK_SELECT: read_word = serial_port_a_clock_select_reg;
                `OFS_SERIAL_PORT_B_CLOCK_SELECT: read_word = serial_port_b_clock_select_reg;
                `OFS_TWO_WIRE_PORT_CLOCK_SELECT: read_word = two_wire_port_clock_select_reg;
                `OFS_SYNC_SERIAL_CLOCK_SELECT: read_word = sync_serial_clock_select_reg;
                `OFS_FRACTIONAL_DIVIDER_VALUE: read_word = fractional_divider_value_reg;
                `OFS_FRACTIONAL_MULTIPLIER_VALUE: read_word = fractional_multiplier_value_reg;
                `OFS_FRACTIONAL_SOURCE_SELECT: read_word = fractional_source_select_reg;
                `OFS_CLOCK_OUTPUT_SOURCE_SELECT: read_word = clock_output_source_select_reg;
                `OFS_CLOCK_OUTPUT_DIVIDER: read_word = clock_output_divider_reg;
                `OFS_ANALOG_POWER_DOWN: read_word = analog_power_down;
                `OFS_SLEEP_KEEP_RUNNING: read_word = sleep_keep_running;
                `OFS_WAKE_ENABLE: read_word = wake_enable;
                default: begin
                    if (chan != 4'hF)
                        read_word = {{(32-PIN_SEL_WIDTH){1'b0}}, pin_route_mem[chan[2:0]]};
                end
            endcase
        end
    endfunction

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    // Word offset only: low two address bits are ignored
    assign offset = {haddr[`FLD_ADDR_MSB:2], 2'b00};
    assign address_taken = hsel && htrans[1] && hready;
    // Reads take one wait state so a write just before is always seen
    assign hreadyout = !read_pending_reg;
    assign hresp = 1'b0;
    assign read_value = read_word(phase_addr_reg);

    always @(posedge core_clk) begin
        if (!reset_n) begin
            write_pending_reg <= 1'b0;
            read_pending_reg <= 1'b0;
            phase_addr_reg <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (read_pending_reg) begin
                hrdata <= read_value;
                read_pending_reg <= 1'b0;
            end else begin
                write_pending_reg <= address_taken && hwrite;
                read_pending_reg <= address_taken && !hwrite;
                if (address_taken)
                    phase_addr_reg <= offset;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    wire [3:0] write_chan;
    assign write_chan = route_channel(phase_addr_reg);

    always @(posedge core_clk) begin
        if (!reset_n) begin
            // Values match what boot code would have left behind
            memory_remap_control_reg <= `RST_MEMORY_REMAP_CONTROL;
            reset_cause_status_reg <= `RST_ZERO;
            main_clock_source_select_reg <= `RST_ZERO;
            main_clock_source_update_reg <= `RST_ZERO;
            system_clock_divider_reg <= `RST_SYSTEM_CLOCK_DIVIDER;
            converter_clock_source_select_reg <= `RST_ZERO;
            converter_clock_divider_reg <= `RST_ZERO;
            low_power_osc_clock_gate_reg <= `RST_LOW_POWER_OSC_CLOCK_GATE;
            system_clock_gate_control_reg <= `RST_SYSTEM_CLOCK_GATE_CONTROL;
            peripheral_reset_control_a_reg <= `RST_PERIPHERAL_RESET_CONTROL_A;
            peripheral_reset_control_b_reg <= `RST_PERIPHERAL_RESET_CONTROL_B;
            serial_port_a_clock_select_reg <= `RST_FUNCTION_CLOCK_SELECT;
            serial_port_b_clock_select_reg <= `RST_FUNCTION_CLOCK_SELECT;
            two_wire_port_clock_select_reg <= `RST_FUNCTION_CLOCK_SELECT;
            sync_serial_clock_select_reg <= `RST_FUNCTION_CLOCK_SELECT;
            fractional_divider_value_reg <= `RST_ZERO;
            fractional_multiplier_value_reg <= `RST_ZERO;
            fractional_source_select_reg <= `RST_ZERO;
            clock_output_source_select_reg <= `RST_ZERO;
            clock_output_divider_reg <= `RST_ZERO;
            analog_power_down <= `RST_ZERO;
            sleep_keep_running <= `RST_ZERO;
            wake_enable <= `RST_ZERO;
            main_clock_active_select <= 3'h0;
            for (i = 0; i < PIN_CHANNELS; i = i + 1)
                pin_route_mem[i] <= {PIN_SEL_WIDTH{1'b0}};
        end else if (clk_en) begin
            // Cause bits: write one clears, a new event in the same cycle wins
            reset_cause_status_reg <= (reset_cause_status_reg
                & ~((write_pending_reg && phase_addr_reg == `OFS_RESET_CAUSE_STATUS)
                    ? hwdata : 32'h0000_0000))
                | {{(31-`FLD_CAUSE_MSB){1'b0}}, reset_cause_event};
            // New main source only lands on a rising update bit
            if (write_pending_reg && phase_addr_reg == `OFS_MAIN_CLOCK_SOURCE_UPDATE
                    && hwdata[`FLD_UPDATE_BIT] && !main_clock_source_update_reg[`FLD_UPDATE_BIT])
                main_clock_active_select <= main_clock_source_select_reg[`FLD_SEL_MSB:0];
            if (write_pending_reg) begin
                case (phase_addr_reg)
                    `OFS_MEMORY_REMAP_CONTROL: memory_remap_control_reg <= hwdata;
                    `OFS_MAIN_CLOCK_SOURCE_SELECT: main_clock_source_select_reg <= hwdata;
                    `OFS_MAIN_CLOCK_SOURCE_UPDATE: main_clock_source_update_reg <= hwdata;
                    `OFS_SYSTEM_CLOCK_DIVIDER: system_clock_divider_reg <= hwdata;
                    `OFS_CONVERTER_CLOCK_SOURCE_SELECT: converter_clock_source_select_reg <= hwdata;
                    `OFS_CONVERTER_CLOCK_DIVIDER: converter_clock_divider_reg <= hwdata;
                    `OFS_LOW_POWER_OSC_CLOCK_GATE: low_power_osc_clock_gate_reg <= hwdata;
                    `OFS_SYSTEM_CLOCK_GATE_CONTROL: system_clock_gate_control_reg <= hwdata;
                    `OFS_PERIPHERAL_RESET_CONTROL_A: peripheral_reset_control_a_reg <= hwdata;
                    `OFS_PERIPHERAL_RESET_CONTROL_B: peripheral_reset_control_b_reg <= hwdata;
                    `OFS_SERIAL_PORT_A_CLOCK_SELECT: serial_port_a_clock_select_reg <= hwdata;
                    `OFS_SERIAL_PORT_B_CLOCK_SELECT: serial_port_b_clock_select_reg <= hwdata;
                    `OFS_TWO_WIRE_PORT_CLOCK_SELECT: two_wire_port_clock_select_reg <= hwdata;
                    `OFS_SYNC_SERIAL_CLOCK_SELECT: sync_serial_clock_select_reg <= hwdata;
                    `OFS_FRACTIONAL_DIVIDER_VALUE: fractional_divider_value_reg <= hwdata;
                    `OFS_FRACTIONAL_MULTIPLIER_VALUE: fractional_multiplier_value_reg <= hwdata;
                    `OFS_FRACTIONAL_SOURCE_SELECT: fractional_source_select_reg <= hwdata;
                    `OFS_CLOCK_OUTPUT_SOURCE_SELECT: clock_output_source_select_reg <= hwdata;
                    `OFS_CLOCK_OUTPUT_DIVIDER: clock_output_divider_reg <= hwdata;
                    `OFS_ANALOG_POWER_DOWN: analog_power_down <= hwdata;
                    `OFS_SLEEP_KEEP_RUNNING: sleep_keep_running <= hwdata;
                    `OFS_WAKE_ENABLE: wake_enable <= hwdata;
                    default: begin
                        // Reserved offsets fall here and change nothing
                        if (write_chan != 4'hF)
                            pin_route_mem[write_chan[2:0]] <= hwdata[PIN_SEL_WIDTH-1:0];
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Clock dividers
    // ****************************************
    clock_tick_divider #(
        .WIDTH(DIV_WIDTH)
    ) system_divider (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .divide(system_clock_divider_reg[DIV_WIDTH-1:0]),
        .tick(system_clock_tick)
    );

    clock_tick_divider #(
        .WIDTH(DIV_WIDTH)
    ) converter_divider (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .divide(converter_clock_divider_reg[DIV_WIDTH-1:0]),
        .tick(converter_clock_tick)
    );

    wire clock_output_tick;

    clock_tick_divider #(
        .WIDTH(DIV_WIDTH)
    ) output_divider (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .divide(clock_output_divider_reg[DIV_WIDTH-1:0]),
        .tick(clock_output_tick)
    );

    // ****************************************
    // Clock gating and output pin
    // ****************************************
    always @(posedge core_clk) begin
        if (!reset_n) begin
            clock_output_pin <= 1'b0;
            peripheral_clock_enable <= 32'h0000_0000;
        end else if (clk_en) begin
            // Divider zero holds the pin low rather than leaving it mid-cycle
            if (clock_output_divider_reg[DIV_WIDTH-1:0] == {DIV_WIDTH{1'b0}})
                clock_output_pin <= 1'b0;
            else if (clock_output_tick)
                clock_output_pin <= !clock_output_pin;
            // Enables follow the system tick, so a stopped system clock stops all
            peripheral_clock_enable <= system_clock_gate_control_reg
                & {32{system_clock_tick}};
        end
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    assign memory_remap = memory_remap_control_reg[`FLD_REMAP_MSB:0];
    // A set bit releases the peripheral, a clear bit holds it in reset
    assign peripheral_reset_a_n = peripheral_reset_control_a_reg;
    assign peripheral_reset_b_n = peripheral_reset_control_b_reg;
    assign converter_clock_select = converter_clock_source_select_reg[`FLD_SEL_MSB:0];
    assign watchdog_lposc_clock_enable = low_power_osc_clock_gate_reg[`FLD_GATE_BIT];
    assign serial_port_a_source = serial_port_a_clock_select_reg[`FLD_SEL_MSB:0];
    assign serial_port_b_source = serial_port_b_clock_select_reg[`FLD_SEL_MSB:0];
    assign two_wire_port_source = two_wire_port_clock_select_reg[`FLD_SEL_MSB:0];
    assign sync_serial_source = sync_serial_clock_select_reg[`FLD_SEL_MSB:0];
    assign fractional_divider = fractional_divider_value_reg[DIV_WIDTH-1:0];
    assign fractional_multiplier = fractional_multiplier_value_reg[DIV_WIDTH-1:0];
    assign fractional_source = fractional_source_select_reg[`FLD_SEL_MSB:0];
    assign clock_output_source = clock_output_source_select_reg[`FLD_SEL_MSB:0];

    genvar g;
    generate
        for (g = 0; g < PIN_CHANNELS; g = g + 1) begin : route_out
            assign pin_interrupt_route[g*PIN_SEL_WIDTH +: PIN_SEL_WIDTH] = pin_route_mem[g];
        end
    endgenerate
endmodule // system_config_clock_reset_bank

// >>> verif/sys_cfg_chk.sv
`timescale 1ns/1ns
// ****************************************
// Bus handshake and reset state checks
// ****************************************
module sys_cfg_chk (
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [1:0] memory_remap,
    input wire watchdog_lposc_clock_enable,
    input wire [31:0] peripheral_reset_b_n,
    input wire system_clock_tick,
    input wire clock_output_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire take = hsel & htrans[1] & hready & clk_en;
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    sequence s_rel; $rose(reset_n); endsequence
    property p_read; take && !hwrite |=> s_wait; endproperty
    property p_write; take && hwrite |=> hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_remap; s_rel |-> memory_remap == 2'h2; endproperty
    property p_lposc; s_rel |-> watchdog_lposc_clock_enable; endproperty
    property p_rstb; s_rel |-> peripheral_reset_b_n == 32'h1F; endproperty
    // Divider resets to one, so the tick runs every cycle once started
    property p_tick; s_rel |-> ##2 system_clock_tick [*3]; endproperty
    property p_pin; s_rel |-> !clock_output_pin [*4]; endproperty
    a_read: assert property (p_read)
        else $error("read wait state wrong");
    a_write: assert property (p_write)
        else $error("write stalled");
    a_okay: assert property (p_okay)
        else $error("response not okay");
    a_remap: assert property (p_remap)
        else $error("remap reset value wrong");
    a_lposc: assert property (p_lposc)
        else $error("oscillator gate reset value wrong");
    a_rstb: assert property (p_rstb)
        else $error("reset control b reset value wrong");
    a_tick: assert property (p_tick)
        else $error("system tick wrong after reset");
    a_pin: assert property (p_pin)
        else $error("clock output not idle after reset");
endmodule // sys_cfg_chk

bind system_config_clock_reset_bank sys_cfg_chk sys_cfg_chk_inst (.core_clk, .reset_n,
    .clk_en, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .memory_remap,
    .watchdog_lposc_clock_enable, .peripheral_reset_b_n, .system_clock_tick, .clock_output_pin);

// >>> verif/system_config_clock_reset_bank_tb_top.sv
`timescale 1ns/1ns
module system_config_clock_reset_bank_tb_top;
    logic core_clk = 0, reset_n = 0, clk_en = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [4:0] reset_cause_event = 0;
    wire hready, hreadyout, hresp, system_clock_tick, converter_clock_tick, clock_output_pin;
    wire [31:0] hrdata, peripheral_reset_b_n, analog_power_down, sleep_keep_running, wake_enable;
    wire [39:0] pin_interrupt_route;
    wire [2:0] main_clock_active_select, serial_port_a_source;
    wire [2:0] clks = {converter_clock_tick, clock_output_pin, system_clock_tick};
    int fail_count = 0, check_count = 0, k, i;
    logic [11:0] ofs [20] = '{12'h000, 12'h038, 12'h050, 12'h054, 12'h058, 12'h064, 12'h068,
        12'h07C, 12'h080, 12'h088, 12'h08C, 12'h090, 12'h094, 12'h0A4, 12'h0B4, 12'h0D0,
        12'h0D4, 12'h0D8, 12'h0F0, 12'h0F4};
    logic [31:0] rst [20] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1,
        32'h17, 32'h0FFF_FFFF, 32'h1F, 32'h7, 32'h7, 32'h7, 32'h7, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0};
    logic [11:0] rsv [3] = '{12'h004, 12'h05C, 12'h100};
    assign hready = hreadyout;
    system_config_clock_reset_bank system_config_clock_reset_bank_inst (.*,
        .memory_remap(), .peripheral_reset_a_n(), .peripheral_clock_enable(),
        .converter_clock_select(), .watchdog_lposc_clock_enable(), .serial_port_b_source(),
        .two_wire_port_source(), .sync_serial_source(), .fractional_divider(),
        .fractional_multiplier(), .fractional_source(), .clock_output_source());
    initial forever #10 core_clk = ~core_clk;
    // ****************************************
    // Tasks
    // ****************************************
    task report_and_stop;
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Looked at on the falling edge, where nothing races the rising edge
    task wait_rdy;
        int n;
        n = 0;
        do begin @(negedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        q = hrdata;
        if (hreadyout !== 1'b1) begin fail_count++; report_and_stop; end
        @(posedge core_clk);
    endtask
    task xfer(input [11:0] a, input w, input [31:0] d);
        hsel <= 1; haddr <= {20'h0, a}; hwrite <= w; htrans <= 2'b10;
        wait_rdy;
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        wait_rdy;
    endtask
    task rises(input int s, input int n, output int c);
        logic p;
        c = 0;
        @(negedge core_clk); p = clks[s];
        repeat (n) begin
            @(negedge core_clk); if (clks[s] && !p) c++; p = clks[s];
        end
        @(posedge core_clk);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1;
        for (i = 0; i < 20; i++) begin xfer(ofs[i], 0, 0); chk(q, rst[i]); end
        xfer(12'h050, 1, 3); xfer(12'h050, 0, 0); chk(main_clock_active_select, 0);
        xfer(12'h054, 1, 1); xfer(12'h054, 0, 0); chk(main_clock_active_select, 3);
        reset_cause_event <= 5'h13; @(posedge core_clk); reset_cause_event <= 0;
        xfer(12'h038, 0, 0); chk(q, 32'h13);
        xfer(12'h038, 1, 3); xfer(12'h038, 0, 0); chk(q, 32'h10);
        for (i = 0; i < 20; i++) xfer(ofs[i], 1, 32'h5A5A_5A00 | i);
        // The stray all-ones write goes to reserved offset 100h; all three reserved offsets must still read zero
        xfer(12'h100, 1, '1);
        for (i = 0; i < 3; i++) begin
            xfer(rsv[i], 0, 0); chk(q, 0);
        end
        for (i = 0; i < 20; i++) begin
            xfer(ofs[i], 0, 0); chk(q, i == 1 ? 32'h10 : 32'h5A5A_5A00 | i);
        end
        chk(peripheral_reset_b_n, 32'h5A5A_5A0A);
        chk(serial_port_a_source, 3);
        xfer(12'h058, 1, 0); rises(0, 30, k); chk(k, 0);
        xfer(12'h058, 1, 3); rises(0, 30, k); chk(k, 10);
        xfer(12'h068, 1, 5); rises(2, 30, k); chk(k, 6);
        // Park the output divider at zero first so the pin phase is known
        xfer(12'h0F4, 1, 0); rises(1, 4, k); chk(clock_output_pin, 0);
        xfer(12'h0F4, 1, 2); rises(1, 40, k); chk(k, 10);
        clk_en <= 0; rises(1, 20, k); chk(k, 0);
        clk_en <= 1;
        xfer(12'h194, 1, 32'h15); xfer(12'h200, 1, 7);
        xfer(12'h204, 1, 3); xfer(12'h208, 1, 9);
        xfer(12'h194, 0, 0); chk(q, 32'h15);
        chk(pin_interrupt_route[39:35], 5'h15);
        chk(analog_power_down, 7);
        chk(sleep_keep_running, 3);
        chk(wake_enable, 9);
        report_and_stop;
    end
endmodule // system_config_clock_reset_bank_tb_top
